// >>> spi_timeout_watchdog.sv
`timescale 1ns/1ps
// Contract
// - period_select picks short or long period
// - short period 50 ms, long 200 ms
// - timer starts at reset; service by inverting
// - valid toggle restarts counter at once
// - counter reaching period flags failure
// - rewriting same trigger value flags failure
// - failure latches fail-safe, defaults, drivers off
// - foreign frame in exit sequence restarts it
// - timer_position reports current quarter of period
// - short period: position not zeroed after timeout
// - watchdog active after reset without configuration
// - unlock frame then watchdog_off frame disables
// - unlock self-clears after the following frame
// - writing watchdog_off 0 re-enables immediately
// - undervoltage reset clears all, drivers off
module spi_timeout_watchdog
  import wdog_pkg::*;
#(
  parameter int SHORT_CYCLES = SHORT_PERIOD_CYCLES,
  parameter int LONG_CYCLES  = LONG_PERIOD_CYCLES,
  parameter int CNT_W        = PERIOD_CNT_W
)(
  input  wire logic       CLOCK,
  input  wire logic       RSTN,
  input  wire logic       SPI_SCK,
  input  wire logic       SPI_CS_N,
  input  wire logic       SPI_MOSI,
  output logic            SPI_MISO,
  output logic            FAIL_SAFE,
  output logic            DRIVERS_OFF,
  output logic [1:0]      TIMER_POSITION,
  output logic            PERIOD_SELECT,
  output logic            WATCHDOG_OFF
);

  if (SHORT_CYCLES < 4 || LONG_CYCLES <= SHORT_CYCLES || LONG_CYCLES >= (2 ** CNT_W))
  begin : g_bad_params
    $error("watchdog period parameters do not fit the counter");
  end

  function automatic logic [1:0] quarter_of(input logic [CNT_W-1:0] c,
                                            input logic [CNT_W-1:0] p);
    logic [CNT_W-1:0] q;
    q = p >> 2;
    if (c >= p - q)
      quarter_of = POS_Q3;
    else if (c >= (p >> 1))
      quarter_of = POS_Q2;
    else if (c >= q)
      quarter_of = POS_Q1;
    else
      quarter_of = POS_RESET;
  endfunction : quarter_of

  // link inputs: two flops, then an edge reference stage
  logic                  sck_s1, sck_s2, sck_q;
  logic                  csn_s1, csn_s2, csn_q;
  logic                  mosi_s1, mosi_s2;
  logic [FRAME_BITS-1:0] rx_shift, tx_shift, fdata, status_word;
  logic [BIT_CNT_W-1:0]  bit_cnt;
  logic                  frame_done, miso;

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      {sck_s1, sck_s2, sck_q}    <= 3'h0;
      {csn_s1, csn_s2, csn_q}    <= 3'h7;
      {mosi_s1, mosi_s2}         <= 2'h0;
    end
    else
    begin
      sck_s1  <= SPI_SCK;
      sck_s2  <= sck_s1;
      sck_q   <= sck_s2;
      csn_s1  <= SPI_CS_N;
      csn_s2  <= csn_s1;
      csn_q   <= csn_s2;
      mosi_s1 <= SPI_MOSI;
      mosi_s2 <= mosi_s1;
    end
  end

  wire sck_rise = sck_s2 & ~sck_q;
  wire sck_fall = ~sck_s2 & sck_q;
  wire csn_fall = ~csn_s2 & csn_q;
  wire csn_rise = csn_s2 & ~csn_q;

  // receive: sample on rising clock edge; only full-length frames count
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rx_shift   <= '0;
      bit_cnt    <= '0;
      frame_done <= 1'b0;
      fdata      <= '0;
    end
    else
    begin
      frame_done <= 1'b0;
      if (csn_fall)
        bit_cnt <= '0;
      else if (!csn_s2 && sck_rise)
      begin
        rx_shift <= {rx_shift[FRAME_BITS-2:0], mosi_s2};
        if (bit_cnt != '1)
          bit_cnt <= bit_cnt + 1'b1;
      end
      if (csn_rise)
      begin
        frame_done <= (bit_cnt == BIT_CNT_W'(FRAME_BITS));
        fdata      <= rx_shift;
      end
    end
  end

  wire                  f_write    = fdata[WRITE_BIT];
  wire [ADDR_W-1:0]     f_addr     = fdata[ADDR_MSB:ADDR_LSB];
  wire                  wr_status  = frame_done & f_write & (f_addr == ADDR_GENERAL_STATUS);
  wire                  wr_ctrl1   = frame_done & f_write & (f_addr == ADDR_GENERAL_CTRL1);
  wire                  wr_ctrl2   = frame_done & f_write & (f_addr == ADDR_GENERAL_CTRL2);
  wire                  f_trig     = fdata[TRIGGER_BIT];

  // watchdog state
  logic             trigger_toggle, period_select, unlock, watchdog_off;
  logic             fail_safe, drivers_off, pos_hold, first_cycle;
  logic [1:0]       position;
  logic [CNT_W-1:0] cnt;
  fs_state_e        fs_state;

  wire [CNT_W-1:0] period = period_select ? CNT_W'(LONG_CYCLES) : CNT_W'(SHORT_CYCLES);
  wire timeout    = ~watchdog_off & (cnt == period - 1'b1);
  wire same_value = wr_ctrl1 & (f_trig == trigger_toggle);
  wire fail       = ~fail_safe & ~watchdog_off & (timeout | same_value);
  wire valid_trig = wr_ctrl1 & ~fail_safe & (f_trig != trigger_toggle);
  wire fs_step    = fail_safe & wr_ctrl1 &
                    (((fs_state == FS_WAIT_SET) & f_trig) |
                     ((fs_state == FS_WAIT_RESET) & ~f_trig));
  wire exit_done  = fs_step & (fs_state == FS_WAIT_RESET);

  // control registers; forced to defaults while in fail-safe
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      trigger_toggle <= TRIGGER_RESET;
      period_select  <= PERIOD_RESET;
      unlock         <= 1'b0;
      watchdog_off   <= WDOFF_RESET;
    end
    else if (fail || fail_safe)
    begin
      trigger_toggle <= TRIGGER_RESET;
      period_select  <= PERIOD_RESET;
      unlock         <= 1'b0;
      watchdog_off   <= WDOFF_RESET;
    end
    else if (frame_done)
    begin
      unlock <= wr_ctrl1 & fdata[UNLOCK_BIT];
      if (wr_ctrl1)
      begin
        trigger_toggle <= f_trig;
        period_select  <= fdata[PERIOD_BIT];
      end
      if (wr_ctrl2 && fdata[WDOFF_BIT] && unlock)
        watchdog_off <= 1'b1;
      else if (wr_ctrl2 && !fdata[WDOFF_BIT])
        watchdog_off <= 1'b0;
    end
  end

  // period counter; a disabled watchdog holds it at zero
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      cnt <= '0;
    else if (watchdog_off || valid_trig || timeout || fs_step || fail)
      cnt <= '0;
    else
      cnt <= cnt + 1'b1;
  end

  // exit sequence; any foreign frame sends it back to the start
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      fs_state <= FS_NONE;
    else
    begin
      case (fs_state)
        FS_NONE:
          if (fail)
            fs_state <= FS_WAIT_CLEAR;
        FS_WAIT_CLEAR:
          if (wr_status)
            fs_state <= FS_WAIT_SET;
        FS_WAIT_SET, FS_WAIT_RESET:
          if (frame_done)
          begin
            if (fs_step)
              fs_state <= (fs_state == FS_WAIT_SET) ? FS_WAIT_RESET : FS_NONE;
            else
              fs_state <= wr_status ? FS_WAIT_SET : FS_WAIT_CLEAR;
          end
          else if (timeout)
            fs_state <= FS_WAIT_CLEAR;
        default:
          fs_state <= FS_WAIT_CLEAR;
      endcase
    end
  end

  // drivers_off switches in the same cycle as fail_safe but is already set in reset
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      fail_safe   <= 1'b0;
      drivers_off <= 1'b1;
    end
    else
    begin
      if (fail)
        fail_safe <= 1'b1;
      else if (exit_done)
        fail_safe <= 1'b0;
      drivers_off <= fail | (fail_safe & ~exit_done);
    end
  end

  // position monitor; a short-period timeout freezes it until the trigger-set write of the exit sequence
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      position <= POS_RESET;
      pos_hold <= 1'b0;
    end
    else
    begin
      if (watchdog_off || period_select || valid_trig || fs_step)
        pos_hold <= 1'b0;
      else if (timeout)
        pos_hold <= 1'b1;
      if (watchdog_off)
        position <= POS_RESET;
      else if (!(pos_hold || (timeout && !period_select)))
        position <= quarter_of(cnt, period);
    end
  end

  // data output: status loaded at frame start, shifted on falling clock
  always_comb
  begin
    status_word                          = '0;
    status_word[ST_FAIL_SAFE_BIT]        = fail_safe;
    status_word[ST_POS_MSB:ST_POS_LSB]   = position;
    status_word[ST_PERIOD_BIT]           = period_select;
    status_word[ST_WDOFF_BIT]            = watchdog_off;
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tx_shift <= '0;
      miso     <= 1'b0;
    end
    else if (csn_fall)
    begin
      tx_shift <= status_word;
      miso     <= status_word[FRAME_BITS-1];
    end
    else if (!csn_s2 && sck_fall)
    begin
      tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b0};
      miso     <= tx_shift[FRAME_BITS-2];
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      first_cycle <= 1'b1;
    else
      first_cycle <= 1'b0;
  end

  assign SPI_MISO       = miso;
  assign FAIL_SAFE      = fail_safe;
  assign DRIVERS_OFF    = drivers_off;
  assign TIMER_POSITION = position;
  assign PERIOD_SELECT  = period_select;
  assign WATCHDOG_OFF   = watchdog_off;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  a_long_not_short: assert property (
    (period_select && !watchdog_off && cnt == CNT_W'(SHORT_CYCLES - 1)) |-> !timeout)
    else $error("long period expired at short count");
  a_short_expiry: assert property (
    (!fail_safe && !watchdog_off && !period_select && !frame_done &&
     cnt == CNT_W'(SHORT_CYCLES - 1)) |=> fail_safe && cnt == '0)
    else $error("short period expiry did not fail");
  a_starts_active: assert property (
    first_cycle |-> !watchdog_off && !trigger_toggle && !fail_safe)
    else $error("watchdog not active after reset");
  // a disabled watchdog holds the counter, and a timeout in the same cycle wins
  a_service_restart: assert property (
    (valid_trig && !watchdog_off && !timeout) |=> cnt == '0 && !fail_safe ##1 cnt == CNT_W'(1))
    else $error("valid service did not restart the counter");
  a_same_value: assert property (
    (same_value && !fail_safe && !watchdog_off) |=> fail_safe && !trigger_toggle)
    else $error("same value write did not fail");
  a_failsafe_hold: assert property (
    (fail_safe ##1 fail_safe) |-> drivers_off && !period_select && !watchdog_off && !unlock)
    else $error("fail-safe did not hold defaults");
  a_exit_broken: assert property (
    (fs_state == FS_WAIT_RESET && frame_done && !fs_step) |=> fail_safe ##1 fail_safe)
    else $error("interrupted exit left fail-safe");
  a_position_track: assert property (
    (!watchdog_off && !pos_hold && !timeout) |=> position == quarter_of($past(cnt), $past(period)))
    else $error("timer position wrong");
  a_short_pos_hold: assert property (
    (timeout && !period_select) |=> (position == $past(position)) [*2])
    else $error("position cleared after short timeout");
  a_off_needs_unlock: assert property (
    $rose(watchdog_off) |-> $past(unlock) && $past(wr_ctrl2))
    else $error("watchdog disabled without unlock");
  a_unlock_clear: assert property (
    (unlock && frame_done && !wr_ctrl1) |=> !unlock)
    else $error("unlock did not self-clear");
  // only a write that actually re-enables restarts the counter from zero
  a_reenable: assert property (
    (wr_ctrl2 && !fdata[WDOFF_BIT] && watchdog_off) |=>
      !watchdog_off ##1 (cnt == CNT_W'(1) || fail_safe))
    else $error("watchdog not re-enabled");

  c_timeout_fail: cover property (timeout && !fail_safe && !watchdog_off ##1 fail_safe);
  c_same_fail:    cover property (same_value && !fail_safe && !watchdog_off);
  c_exit_done:    cover property (exit_done ##1 !fail_safe);
  c_disabled:     cover property ($rose(watchdog_off));

endmodule : spi_timeout_watchdog

// >>> wdog_pkg.sv
package wdog_pkg;
  // timing
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int NS_PER_MS       = 1_000_000;
  localparam int SHORT_PERIOD_MS = 50;
  localparam int LONG_PERIOD_MS  = 200;
  localparam int SHORT_PERIOD_CYCLES = SHORT_PERIOD_MS * NS_PER_MS / CLOCK_PERIOD_NS;
  localparam int LONG_PERIOD_CYCLES  = LONG_PERIOD_MS * NS_PER_MS / CLOCK_PERIOD_NS;
  localparam int PERIOD_CNT_W        = 26;

  // frame layout: write flag, address, data
  localparam int FRAME_BITS    = 24;
  localparam int BIT_CNT_W     = 5;
  localparam int WRITE_BIT     = 23;
  localparam int ADDR_MSB      = 22;
  localparam int ADDR_LSB      = 16;
  localparam int ADDR_W        = 7;
  localparam logic [ADDR_W-1:0] ADDR_GENERAL_STATUS = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_GENERAL_CTRL1  = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_GENERAL_CTRL2  = 7'h02;

  // general_control_one fields
  localparam int TRIGGER_BIT = 0;
  localparam int PERIOD_BIT  = 1;
  localparam int UNLOCK_BIT  = 2;
  // general_control_two fields
  localparam int WDOFF_BIT   = 0;

  // status word shifted out on the data output
  localparam int ST_FAIL_SAFE_BIT = 23;
  localparam int ST_POS_MSB       = 22;
  localparam int ST_POS_LSB       = 21;
  localparam int ST_PERIOD_BIT    = 20;
  localparam int ST_WDOFF_BIT     = 19;

  // reset values
  localparam logic       TRIGGER_RESET = 1'b0;
  localparam logic       PERIOD_RESET  = 1'b0;
  localparam logic       WDOFF_RESET   = 1'b0;
  localparam logic [1:0] POS_RESET     = 2'h0;
  localparam logic [1:0] POS_Q1        = 2'h1;
  localparam logic [1:0] POS_Q2        = 2'h2;
  localparam logic [1:0] POS_Q3        = 2'h3;

  typedef enum logic [1:0] {FS_NONE, FS_WAIT_CLEAR, FS_WAIT_SET, FS_WAIT_RESET} fs_state_e;
endpackage : wdog_pkg

// >>> spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // link clock stands still low outside frames
  initial
  begin
    sck  = 1'h0;
    cs_n = 1'h1;
    mosi = 1'h0;
  end

  task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
    cs_n = 1'h0;
    for (int i = 23; i >= 0; i--)
    begin
      mosi = tx[i];
      #62.5 sck = 1'h1;
      rx[i] = miso;
      #62.5 sck = 1'h0;
    end
    #62.5 cs_n = 1'h1;
    // released line shows the inverse so a stale bit cannot pass
    mosi = ~mosi;
    #100;
  endtask : frame
endmodule : spi_master_model

// >>> spi_timeout_watchdog_test.sv
`timescale 1ns/1ps
module spi_timeout_watchdog_test
  import wdog_pkg::*;
;
  // short counts keep the run brief; a frame is about 800 cycles
  localparam int SHORT = 8000;
  localparam int LONG  = 12000;
  localparam int LIMIT = 70000;
  typedef struct packed {
    logic [23:0] word;
    logic        fs;
    logic        ps;
    logic        off;
  } row_s;
  logic        clock;
  logic        rstn;
  logic        sck, cs_n, mosi, miso;
  logic        fail_safe, drivers_off, ps, off;
  logic [1:0]  pos;
  logic [23:0] rx;
  logic [2:0]  prev = 3'h0;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cycles = 0;
  row_s        rows [18] = '{
    '{24'h81_0001, 1'h0, 1'h0, 1'h0},
    '{24'h81_0002, 1'h0, 1'h1, 1'h0},
    '{24'h81_0001, 1'h0, 1'h0, 1'h0},
    '{24'h81_0001, 1'h1, 1'h0, 1'h0},
    '{24'h00_0000, 1'h1, 1'h0, 1'h0},
    '{24'h80_0000, 1'h1, 1'h0, 1'h0},
    '{24'h81_0001, 1'h1, 1'h0, 1'h0},
    '{24'h00_0000, 1'h1, 1'h0, 1'h0},
    '{24'h80_0000, 1'h1, 1'h0, 1'h0},
    '{24'h81_0001, 1'h1, 1'h0, 1'h0},
    '{24'h81_0000, 1'h0, 1'h0, 1'h0},
    '{24'h81_0001, 1'h0, 1'h0, 1'h0},
    '{24'h81_0004, 1'h0, 1'h0, 1'h0},
    '{24'h00_0000, 1'h0, 1'h0, 1'h0},
    '{24'h82_0001, 1'h0, 1'h0, 1'h0},
    '{24'h81_0005, 1'h0, 1'h0, 1'h0},
    '{24'h82_0001, 1'h0, 1'h0, 1'h1},
    '{24'h82_0000, 1'h0, 1'h0, 1'h0}
  };
  logic [23:0] exit_words [3] = '{24'h80_0000, 24'h81_0001, 24'h81_0000};

  spi_timeout_watchdog #(
    .SHORT_CYCLES (SHORT),
    .LONG_CYCLES  (LONG)
  ) dut (
    .CLOCK          (clock),
    .RSTN           (rstn),
    .SPI_SCK        (sck),
    .SPI_CS_N       (cs_n),
    .SPI_MOSI       (mosi),
    .SPI_MISO       (miso),
    .FAIL_SAFE      (fail_safe),
    .DRIVERS_OFF    (drivers_off),
    .TIMER_POSITION (pos),
    .PERIOD_SELECT  (ps),
    .WATCHDOG_OFF   (off)
  );

  spi_master_model master (
    .sck  (sck),
    .cs_n (cs_n),
    .mosi (mosi),
    .miso (miso)
  );

  initial
  begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  task automatic summarize();
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == LIMIT)
    begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end

  task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_cycles

  initial
  begin
    rstn = 1'h0;
    wait_cycles(8);
    rstn = 1'h1;
    for (int i = 0; i < 18; i++)
    begin
      master.frame(rows[i].word, rx);
      wait_cycles(8);
      check("status", prev, {rx[23], rx[20], rx[19]});
      check("fail_safe", 3'(rows[i].fs), 3'(fail_safe));
      check("drivers_off", 3'(rows[i].fs), 3'(drivers_off));
      check("period_select", 3'(rows[i].ps), 3'(ps));
      check("watchdog_off", 3'(rows[i].off), 3'(off));
      prev = {rows[i].fs, rows[i].ps, rows[i].off};
    end
    $display("table test done");
    master.frame(24'h81_0000, rx);
    wait_cycles(SHORT / 8);
    for (int q = 0; q < 4; q++)
    begin
      check("timer_position", 3'(q), 3'(pos));
      if (q < 3)
        wait_cycles(SHORT / 4);
    end
    wait_cycles(SHORT / 8 - 300);
    check("fail_safe early", 3'h0, 3'(fail_safe));
    wait_cycles(600);
    check("fail_safe timeout", 3'h1, 3'(fail_safe));
    check("frozen position", 3'(POS_Q3), 3'(pos));
    $display("short timeout test done");
    for (int k = 0; k < 3; k++)
      master.frame(exit_words[k], rx);
    wait_cycles(8);
    check("fail_safe exit", 3'h0, 3'(fail_safe));
    master.frame(24'h81_0003, rx);
    wait_cycles(LONG - 300);
    // still safe well past the short period
    check("fail_safe long", 3'h0, 3'(fail_safe));
    wait_cycles(600);
    check("fail_safe long end", 3'h1, 3'(fail_safe));
    check("defaulted period", 3'(PERIOD_RESET), 3'(ps));
    check("long position", 3'(POS_RESET), 3'(pos));
    $display("long timeout test done");
    rstn = 1'h0;
    wait_cycles(3);
    check("reset outputs", 3'h2, {fail_safe, drivers_off, ps});
    check("reset position", 3'(POS_RESET), {off, pos});
    rstn = 1'h1;
    wait_cycles(2);
    check("drivers on", 3'h0, 3'(drivers_off));
    wait_cycles(SHORT * 3 / 8);
    check("running after reset", 3'(POS_Q1), 3'(pos));
    wait_cycles(SHORT * 5 / 8 + 300);
    check("timeout after reset", 3'h1, 3'(fail_safe));
    $display("reset test done");
    summarize();
  end
endmodule : spi_timeout_watchdog_test
